//--- hw/fpmul_pkg.sv
package fpmul_pkg;

  // Operand word: sign, biased exponent, fraction without the hidden bit
  typedef struct packed {
    logic sign;
    logic [7:0] expo;
    logic [54:0] frac;
  } fp_word_t;

  // Floating condition codes
  typedef struct packed {
    logic fp_negative_flag;
    logic fp_zero_flag;
    logic fp_overflow_flag;
    logic fp_carry_flag;
  } cc_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_CALC = 2'b10
  } state_t;

  typedef enum logic [3:0] {
    K_NONE = 4'b0001,
    K_MUL = 4'b0010,
    K_NEG = 4'b0100,
    K_SETS = 4'b1000
  } kind_t;

  typedef enum logic [1:0] {
    TC_NONE = 2'h0,
    TC_UNDEF = 2'h1,
    TC_OVF = 2'h2,
    TC_UNF = 2'h3
  } trap_cause_t;

  // Opcode fields
  localparam logic [7:0] OPC_MUL_HI = 8'hF2;
  localparam logic [9:0] OPC_NEG_HI = 10'h3C7;
  localparam logic [15:0] OPC_SELECT_SINGLE = 16'hF001;
  localparam int AC_MSB = 7;
  localparam int AC_LSB = 6;
  localparam int SPEC_MSB = 5;

  // Product widths kept before rounding
  localparam int PROD_BITS_SINGLE = 48;
  localparam int PROD_BITS_DOUBLE = 59;
  localparam logic [9:0] EXP_BIAS = 10'h080;

  // Cycles from a taken start to the done pulse
  localparam int LATENCY_CYCLES = 2;

  localparam logic DOUBLE_MODE_RESET = 1'b0;

  function automatic kind_t instr_kind(input logic [15:0] instr);
    if (instr[15:8] == OPC_MUL_HI) begin
      instr_kind = K_MUL;
    end else if (instr[15:6] == OPC_NEG_HI) begin
      instr_kind = K_NEG;
    end else if (instr == OPC_SELECT_SINGLE) begin
      instr_kind = K_SETS;
    end else begin
      instr_kind = K_NONE;
    end
  endfunction

endpackage

//--- hw/fp_multiply_negate_unit.sv
// How it works
// [RULE1] Multiply underflow with underflow interrupt off stores exact zero.
// [RULE2] Multiply overflow with overflow interrupt off stores exact zero.
// [RULE3] Multiply opcode holds accumulator in bits 7-6, source in 5-0; product to accumulator.
// [RULE4] Multiply codes: carry clear, overflow on overflow, zero and negative from result.
// [RULE5] Either multiply operand with zero biased exponent gives exact zero.
// [RULE6] Product kept to 48 bits single, 59 bits double, before rounding.
// [RULE7] Chop mode selects truncation, otherwise round to nearest half LSB.
// [RULE8] Negative zero source with undefined trap enabled traps before multiplying.
// [RULE9] Enabled overflow or underflow traps with wrapped exponent, fraction kept.
// [RULE10] Negate flips sign when exponent nonzero, else stores exact zero.
// [RULE11] Negate clears carry and overflow, zero and negative from result.
// [RULE12] Negate never overflows; negative zero with trap enabled traps after execution.
// [RULE13] Negative zero with trap enabled writes exact zero back and sets zero flag.
// [RULE14] Select-single opcode clears the double precision mode bit.
// [RULE15] Precision of multiply and negate follows the double precision mode bit.
`timescale 1ns/1ps
`default_nettype none
module fp_multiply_negate_unit
  import fpmul_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Instruction issue
  input wire logic START,
  input wire logic [15:0] INSTR,
  input wire fp_word_t ACC_IN,
  input wire fp_word_t SRC_IN,
  // Status controls
  input wire logic CHOP_MODE,
  input wire logic UNDERFLOW_INT_ENABLE,
  input wire logic OVERFLOW_INT_ENABLE,
  input wire logic UNDEFINED_VAR_TRAP_ENABLE,
  input wire logic SET_DOUBLE,
  output logic DOUBLE_PRECISION_MODE,
  // Completion
  output logic BUSY,
  output logic DONE,
  output logic RESULT_WR,
  output logic RESULT_TO_AC,
  output logic [1:0] RESULT_AC,
  output logic [5:0] RESULT_SPEC,
  output fp_word_t RESULT_DATA,
  output logic CC_WR,
  output cc_t CC_OUT,
  output logic TRAP,
  output trap_cause_t TRAP_CAUSE
);

  state_t state_r, state_nxt;
  kind_t kind_r, kind_nxt;
  fp_word_t acc_r, acc_nxt, src_r, src_nxt;
  logic [15:0] instr_r, instr_nxt;
  logic dbl_op_r, dbl_op_nxt, chop_r, chop_nxt;
  logic fiu_r, fiu_nxt, fiv_r, fiv_nxt, undefined_var_trap_enable_r, undefined_var_trap_enable_nxt;
  logic dbl_r, dbl_nxt;
  logic done_r, done_nxt, wr_r, wr_nxt, to_ac_r, to_ac_nxt, cc_wr_r, cc_wr_nxt, trap_r, trap_nxt;
  logic [1:0] ac_r, ac_nxt;
  logic [5:0] spec_r, spec_nxt;
  fp_word_t data_r, data_nxt;
  cc_t cc_r, cc_nxt;
  trap_cause_t cause_r, cause_nxt;
  logic ovf_r, ovf_nxt, unf_r, unf_nxt;

  logic [55:0] ma, mb;
  logic [111:0] prod;
  logic [58:0] pt, pn;
  logic nrm, rb;
  logic [56:0] rbase, rinc, rsum;
  logic [55:0] mant;
  logic [9:0] ex;
  logic ovf, unf, zop, src_undef;
  fp_word_t mul_res, neg_res;

  // Mantissas with hidden bit; single operands use the upper 24 bits only
  // [RULE15] mode picks width
  assign ma = dbl_op_r ? {1'b1, acc_r.frac} : {1'b1, acc_r.frac[54:32], 32'h0};
  assign mb = dbl_op_r ? {1'b1, src_r.frac} : {1'b1, src_r.frac[54:32], 32'h0};
  assign prod = ma * mb;
  // [RULE6] truncated product width
  assign pt = dbl_op_r ? prod[111:53] : {prod[111:(112 - PROD_BITS_SINGLE)], 11'h0};
  assign nrm = ~pt[58];
  assign pn = nrm ? {pt[57:0], 1'b0} : pt;
  // [RULE7] chop or round
  assign rb = ~chop_r & (dbl_op_r ? pn[2] : pn[34]);
  assign rbase = dbl_op_r ? {1'b0, pn[58:3]} : {1'b0, pn[58:35], 32'h0};
  assign rinc = dbl_op_r ? {56'h0, rb} : {24'h0, rb, 32'h0};
  assign rsum = rbase + rinc;
  assign mant = rsum[56] ? rsum[56:1] : rsum[55:0];
  assign ex = {2'h0, acc_r.expo} + {2'h0, src_r.expo} - EXP_BIAS - {9'h0, nrm} + {9'h0, rsum[56]};
  assign ovf = ~ex[9] & ex[8];
  assign unf = ex[9] | (ex == 10'h000);
  assign zop = (acc_r.expo == 8'h00) | (src_r.expo == 8'h00);
  assign src_undef = src_r.sign & (src_r.expo == 8'h00);
  // [RULE9] low eight exponent bits give the wrapped value
  assign mul_res = '{sign: acc_r.sign ^ src_r.sign, expo: ex[7:0], frac: mant[54:0]};
  // [RULE10] negate or exact zero
  assign neg_res = (src_r.expo == 8'h00) ? '0 :
    fp_word_t'{sign: ~src_r.sign, expo: src_r.expo, frac: dbl_op_r ? src_r.frac : {src_r.frac[54:32], 32'h0}};

  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    acc_nxt = acc_r;
    src_nxt = src_r;
    instr_nxt = instr_r;
    dbl_op_nxt = dbl_op_r;
    chop_nxt = chop_r;
    fiu_nxt = fiu_r;
    fiv_nxt = fiv_r;
    undefined_var_trap_enable_nxt = undefined_var_trap_enable_r;
    dbl_nxt = dbl_r;
    done_nxt = 1'b0;
    wr_nxt = 1'b0;
    to_ac_nxt = to_ac_r;
    cc_wr_nxt = 1'b0;
    trap_nxt = 1'b0;
    ac_nxt = ac_r;
    spec_nxt = spec_r;
    data_nxt = data_r;
    cc_nxt = cc_r;
    cause_nxt = TC_NONE;
    ovf_nxt = ovf_r;
    unf_nxt = unf_r;
    if (SET_DOUBLE) begin
      dbl_nxt = 1'b1;
    end
    case (state_r)
      S_IDLE: begin
        if (START) begin
          state_nxt = S_CALC;
          kind_nxt = instr_kind(INSTR);
          instr_nxt = INSTR;
          acc_nxt = ACC_IN;
          src_nxt = SRC_IN;
          // [RULE15] precision sampled at issue
          dbl_op_nxt = dbl_r;
          chop_nxt = CHOP_MODE;
          fiu_nxt = UNDERFLOW_INT_ENABLE;
          fiv_nxt = OVERFLOW_INT_ENABLE;
          undefined_var_trap_enable_nxt = UNDEFINED_VAR_TRAP_ENABLE;
          // [RULE14] clear double mode
          if (INSTR == OPC_SELECT_SINGLE) begin
            dbl_nxt = 1'b0;
          end
        end
      end
      S_CALC: begin
        state_nxt = S_IDLE;
        done_nxt = 1'b1;
        ac_nxt = instr_r[AC_MSB:AC_LSB];
        spec_nxt = instr_r[SPEC_MSB:0];
        ovf_nxt = 1'b0;
        unf_nxt = 1'b0;
        case (kind_r)
          K_MUL: begin
            to_ac_nxt = 1'b1;
            if (undefined_var_trap_enable_r && src_undef) begin
              // [RULE8] trap before execution
              trap_nxt = 1'b1;
              cause_nxt = TC_UNDEF;
            end else begin
              wr_nxt = 1'b1;
              cc_wr_nxt = 1'b1;
              if (zop) begin
                // [RULE5] zero exponent operand
                data_nxt = '0;
              end else if (ovf) begin
                ovf_nxt = 1'b1;
                // [RULE2] [RULE9] overflow result
                data_nxt = fiv_r ? mul_res : '0;
                trap_nxt = fiv_r;
                cause_nxt = fiv_r ? TC_OVF : TC_NONE;
              end else if (unf) begin
                unf_nxt = 1'b1;
                // [RULE1] [RULE9] underflow result
                data_nxt = fiu_r ? mul_res : '0;
                trap_nxt = fiu_r;
                cause_nxt = fiu_r ? TC_UNF : TC_NONE;
              end else begin
                // [RULE3] product to accumulator
                data_nxt = mul_res;
              end
              // [RULE4] multiply codes
              cc_nxt.fp_carry_flag = 1'b0;
              cc_nxt.fp_overflow_flag = ovf & ~zop;
              cc_nxt.fp_zero_flag = zop | (ovf & ~fiv_r) | (unf & ~fiu_r) | (mul_res.expo == 8'h00);
              cc_nxt.fp_negative_flag = ~zop & ((ovf & fiv_r) | (unf & fiu_r) | (~ovf & ~unf)) & mul_res.sign;
            end
          end
          K_NEG: begin
            to_ac_nxt = 1'b0;
            wr_nxt = 1'b1;
            cc_wr_nxt = 1'b1;
            // [RULE10] [RULE13] exact zero for zero exponent, including negative zero
            data_nxt = neg_res;
            // [RULE11] [RULE12] negate codes
            cc_nxt.fp_carry_flag = 1'b0;
            cc_nxt.fp_overflow_flag = 1'b0;
            cc_nxt.fp_zero_flag = (neg_res.expo == 8'h00);
            cc_nxt.fp_negative_flag = neg_res.sign;
            // [RULE12] trap after execution
            if (undefined_var_trap_enable_r && src_undef) begin
              trap_nxt = 1'b1;
              cause_nxt = TC_UNDEF;
            end
          end
          default: begin
            wr_nxt = 1'b0;
          end
        endcase
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r <= S_IDLE;
      kind_r <= K_NONE;
      acc_r <= '0;
      src_r <= '0;
      instr_r <= 16'h0000;
      dbl_op_r <= DOUBLE_MODE_RESET;
      chop_r <= 1'b0;
      fiu_r <= 1'b0;
      fiv_r <= 1'b0;
      undefined_var_trap_enable_r <= 1'b0;
      dbl_r <= DOUBLE_MODE_RESET;
      done_r <= 1'b0;
      wr_r <= 1'b0;
      to_ac_r <= 1'b0;
      cc_wr_r <= 1'b0;
      trap_r <= 1'b0;
      ac_r <= 2'h0;
      spec_r <= 6'h00;
      data_r <= '0;
      cc_r <= '0;
      cause_r <= TC_NONE;
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      acc_r <= acc_nxt;
      src_r <= src_nxt;
      instr_r <= instr_nxt;
      dbl_op_r <= dbl_op_nxt;
      chop_r <= chop_nxt;
      fiu_r <= fiu_nxt;
      fiv_r <= fiv_nxt;
      undefined_var_trap_enable_r <= undefined_var_trap_enable_nxt;
      dbl_r <= dbl_nxt;
      done_r <= done_nxt;
      wr_r <= wr_nxt;
      to_ac_r <= to_ac_nxt;
      cc_wr_r <= cc_wr_nxt;
      trap_r <= trap_nxt;
      ac_r <= ac_nxt;
      spec_r <= spec_nxt;
      data_r <= data_nxt;
      cc_r <= cc_nxt;
      cause_r <= cause_nxt;
      ovf_r <= ovf_nxt;
      unf_r <= unf_nxt;
    end
  end

  assign DOUBLE_PRECISION_MODE = dbl_r;
  assign BUSY = state_r[1];
  assign DONE = done_r;
  assign RESULT_WR = wr_r;
  assign RESULT_TO_AC = to_ac_r;
  assign RESULT_AC = ac_r;
  assign RESULT_SPEC = spec_r;
  assign RESULT_DATA = data_r;
  assign CC_WR = cc_wr_r;
  assign CC_OUT = cc_r;
  assign TRAP = trap_r;
  assign TRAP_CAUSE = cause_r;

  logic take;
  assign take = START && (state_r == S_IDLE);

  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  AST_UNF_ZERO: assert property (DONE && kind_r == K_MUL && unf_r && !fiu_r && !trap_r |-> RESULT_WR && RESULT_DATA == '0) // [RULE1]
    else $error("underflow without enable did not store zero");
  AST_OVF_ZERO: assert property (DONE && kind_r == K_MUL && ovf_r && !fiv_r |-> RESULT_WR && RESULT_DATA == '0 && !TRAP) // [RULE2]
    else $error("overflow without enable did not store zero");
  AST_MUL_CC: assert property (DONE && CC_WR && kind_r == K_MUL |-> !CC_OUT.fp_carry_flag && CC_OUT.fp_overflow_flag == ovf_r
    && CC_OUT.fp_zero_flag == (RESULT_DATA.expo == 8'h00) && CC_OUT.fp_negative_flag == RESULT_DATA.sign) // [RULE4]
    else $error("multiply condition codes wrong");
  AST_ZERO_OPERAND: assert property (take && instr_kind(INSTR) == K_MUL && (ACC_IN.expo == 8'h00 || SRC_IN.expo == 8'h00)
    && !(UNDEFINED_VAR_TRAP_ENABLE && SRC_IN.sign && SRC_IN.expo == 8'h00) |-> ##2 DONE && RESULT_WR && RESULT_DATA == '0) // [RULE5]
    else $error("zero exponent operand did not give zero");
  AST_UNDEF_BEFORE: assert property (take && instr_kind(INSTR) == K_MUL && UNDEFINED_VAR_TRAP_ENABLE && SRC_IN.sign
    && SRC_IN.expo == 8'h00 |-> ##2 TRAP && TRAP_CAUSE == TC_UNDEF && !RESULT_WR && !CC_WR) // [RULE8]
    else $error("negative zero source did not trap before multiply");
  AST_TRAP_KEEPS: assert property (TRAP && (TRAP_CAUSE == TC_OVF || TRAP_CAUSE == TC_UNF) |-> RESULT_WR && RESULT_TO_AC) // [RULE9]
    else $error("enabled range trap lost its result");
  AST_NEG_FLIP: assert property (take && instr_kind(INSTR) == K_NEG && SRC_IN.expo != 8'h00
    |-> ##2 RESULT_WR && RESULT_DATA.sign == !$past(SRC_IN.sign, 2) && RESULT_DATA.expo == $past(SRC_IN.expo, 2)) // [RULE10]
    else $error("negate did not flip sign");
  AST_NEG_CC: assert property (DONE && kind_r == K_NEG |-> !CC_OUT.fp_overflow_flag && !CC_OUT.fp_carry_flag
    && (TRAP_CAUSE == TC_NONE || TRAP_CAUSE == TC_UNDEF)) // [RULE12]
    else $error("negate signalled a range condition");
  AST_NEG_UNDEF: assert property (DONE && kind_r == K_NEG && undefined_var_trap_enable_r && src_undef |-> RESULT_DATA == '0
    && CC_OUT.fp_zero_flag && TRAP) // [RULE13]
    else $error("negative zero negate not handled");
  AST_SELECT_SINGLE: assert property (take && INSTR == OPC_SELECT_SINGLE |=> !DOUBLE_PRECISION_MODE) // [RULE14]
    else $error("select single did not clear double mode");

  COV_MUL_OVF_TRAP: cover property (DONE && TRAP && TRAP_CAUSE == TC_OVF);
  COV_MUL_UNF_ZERO: cover property (DONE && kind_r == K_MUL && unf_r && !fiu_r);
  COV_NEG_UNDEF: cover property (DONE && kind_r == K_NEG && TRAP);
  COV_MUL_DOUBLE: cover property (DONE && kind_r == K_MUL && dbl_op_r && !TRAP);

endmodule
`default_nettype wire

//--- sim/fp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fp_host_model
  import fpmul_pkg::*;
(
  // Clock
  input wire logic CLK,
  // Unit status
  input wire logic BUSY,
  input wire logic DONE,
  // Instruction issue
  output logic START,
  output logic [15:0] INSTR,
  output fp_word_t ACC_IN,
  output fp_word_t SRC_IN
);
  int wait_cnt;

  initial begin
    START = 1'b0;
    INSTR = 16'h0000;
    ACC_IN = '0;
    SRC_IN = '0;
    wait_cnt = 0;
  end

  // Issue one instruction and wait a bounded time for its completion
  task automatic issue(input logic [15:0] ins, input fp_word_t a, input fp_word_t b);
    @(negedge CLK);
    while (BUSY) @(negedge CLK);
    START = 1'b1;
    INSTR = ins;
    ACC_IN = a;
    SRC_IN = b;
    @(negedge CLK);
    START = 1'b0;
    // Stale operands shown inverted so a late sample is caught
    INSTR = ~ins;
    ACC_IN = ~a;
    SRC_IN = ~b;
    wait_cnt = 0;
    while (!DONE && wait_cnt < 8) begin
      @(negedge CLK);
      wait_cnt++;
    end
  endtask
endmodule
`default_nettype wire

//--- sim/fp_multiply_negate_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin compares++; \
  if ((gt) !== (ex)) begin err_count++; $display("wrong value %s exp %0h got %0h", nm, ex, gt); end end
module fp_multiply_negate_unit_tb;
  import fpmul_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic chop = 1'b0;
  logic ue = 1'b0;
  logic oe = 1'b0;
  logic te = 1'b0;
  logic setd = 1'b0;
  logic dm = 1'b0;
  logic start, mode, busy, done, wr, to_ac, ccwr, trap;
  logic [15:0] instr;
  logic [1:0] rac;
  logic [5:0] rspec;
  fp_word_t acc, src, rdata;
  cc_t cc;
  trap_cause_t cause;
  int err_count = 0;
  int compares = 0;

  always #2 clk = ~clk;

  fp_multiply_negate_unit u_dut (.CLK(clk), .SYS_RST(rst), .START(start), .INSTR(instr), .ACC_IN(acc),
    .SRC_IN(src), .CHOP_MODE(chop), .UNDERFLOW_INT_ENABLE(ue), .OVERFLOW_INT_ENABLE(oe),
    .UNDEFINED_VAR_TRAP_ENABLE(te), .SET_DOUBLE(setd), .DOUBLE_PRECISION_MODE(mode), .BUSY(busy),
    .DONE(done), .RESULT_WR(wr), .RESULT_TO_AC(to_ac), .RESULT_AC(rac), .RESULT_SPEC(rspec),
    .RESULT_DATA(rdata), .CC_WR(ccwr), .CC_OUT(cc), .TRAP(trap), .TRAP_CAUSE(cause));

  fp_host_model u_host (.CLK(clk), .BUSY(busy), .DONE(done), .START(start), .INSTR(instr),
    .ACC_IN(acc), .SRC_IN(src));

  // Product before range checks: normalise, then chop or add half an LSB
  function automatic fp_word_t mul_ref(fp_word_t a, fp_word_t b, logic d, logic ch,
                                       output logic ov, output logic un);
    logic [111:0] p;
    logic [63:0] q;
    logic [56:0] m;
    int e;
    ov = 1'b0;
    un = 1'b0;
    if (a.expo == 8'h00 || b.expo == 8'h00) return '0;
    e = a.expo + b.expo - 128;
    if (d) begin
      p = {1'b1, a.frac} * {1'b1, b.frac};
      q = {p[111:53], 5'h00};
    end else begin
      p = {1'b1, a.frac[54:32]} * {1'b1, b.frac[54:32]};
      q = {p[47:0], 16'h0000};
    end
    if (!q[63]) begin
      q = q << 1;
      e--;
    end
    m = d ? {1'b0, q[63:8]} + (ch ? 57'h0 : q[7]) : {33'h0, q[63:40]} + (ch ? 57'h0 : q[39]);
    if (d ? m[56] : m[24]) begin
      m = m >> 1;
      e++;
    end
    ov = e > 255;
    un = e <= 0;
    mul_ref.sign = a.sign ^ b.sign;
    mul_ref.expo = e[7:0];
    mul_ref.frac = d ? m[54:0] : {m[22:0], 32'h0};
  endfunction

  function automatic fp_word_t rnd(int lo, int hi);
    fp_word_t w;
    w = {$urandom, $urandom};
    w.expo = 8'($urandom_range(hi, lo));
    return w;
  endfunction

  task automatic mul(logic [1:0] ac, fp_word_t a, fp_word_t b);
    fp_word_t r;
    logic ov, un, negz;
    trap_cause_t tc;
    logic [5:0] sp;
    r = mul_ref(a, b, dm, chop, ov, un);
    negz = te && b.sign && b.expo == 8'h00;
    tc = negz ? TC_UNDEF : (ov && oe) ? TC_OVF : (un && ue) ? TC_UNF : TC_NONE;
    if ((ov && !oe) || (un && !ue)) r = '0;
    sp = 6'($urandom_range(63));
    u_host.issue({8'hF2, ac, sp}, a, b);
    `CHK("latency", LATENCY_CYCLES - 1, u_host.wait_cnt)
    `CHK("mul write", !negz, wr)
    `CHK("mul cc write", !negz, ccwr)
    `CHK("mul cause", tc, cause)
    `CHK("mul trap", tc != TC_NONE, trap)
    if (!negz) begin
      `CHK("mul to ac", 1'b1, to_ac)
      `CHK("mul ac", ac, rac)
      `CHK("mul data", r, rdata)
      // A word whose exponent is zero counts as zero
      `CHK("mul cc", {r.sign, r.expo == 8'h00, ov, 1'b0}, cc)
    end
  endtask

  task automatic unknown_op();
    u_host.issue(16'h0000, rnd(1, 255), rnd(1, 255));
    `CHK("unknown latency", LATENCY_CYCLES - 1, u_host.wait_cnt)
    `CHK("unknown effects", 3'b000, {wr, ccwr, trap})
  endtask

  task automatic neg(fp_word_t a);
    fp_word_t r;
    logic negz;
    logic [5:0] sp;
    negz = te && a.sign && a.expo == 8'h00;
    r = (a.expo == 8'h00) ? '0 : dm ? {~a.sign, a.expo, a.frac} : {~a.sign, a.expo, a.frac[54:32], 32'h0};
    sp = 6'($urandom_range(63));
    u_host.issue({10'h3C7, sp}, rnd(1, 255), a);
    `CHK("neg write", 2'b11, {wr, ccwr})
    `CHK("neg target", {1'b0, sp}, {to_ac, rspec})
    `CHK("neg data", r, rdata)
    `CHK("neg cc", {r.sign, r == '0, 2'b00}, cc)
    `CHK("neg cause", negz ? TC_UNDEF : TC_NONE, cause)
    `CHK("neg trap", negz, trap)
  endtask

  task automatic set_single();
    u_host.issue(OPC_SELECT_SINGLE, rnd(1, 255), rnd(1, 255));
    dm = 1'b0;
    `CHK("sel write", 2'b00, {wr, ccwr})
    `CHK("sel trap", 1'b0, trap)
    `CHK("sel mode", 1'b0, mode)
  endtask

  task automatic set_double();
    @(negedge clk);
    setd = 1'b1;
    @(negedge clk);
    setd = 1'b0;
    dm = 1'b1;
    `CHK("dbl mode", 1'b1, mode)
  endtask

  task automatic conclude();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    conclude();
  end

  initial begin
    void'($urandom(30311));
    repeat (2) @(negedge clk);
    rst = 1'b0;
    `CHK("reset mode", 1'b0, mode)
    `CHK("reset done", 1'b0, done)
    for (int i = 0; i < 60; i++) begin
      if (i % 10 == 0) begin
        if ($urandom_range(1)) set_double();
        else set_single();
      end
      chop = 1'($urandom_range(1));
      if (i % 3 == 2) neg(rnd(0, 255));
      else mul(2'($urandom_range(3)), rnd(64, 192), rnd(64, 192));
    end
    for (int k = 0; k < 2; k++) begin
      if (k == 1) set_double();
      else set_single();
      mul(2'h1, rnd(0, 0), rnd(100, 100));
      mul(2'h2, rnd(100, 100), rnd(0, 0));
      for (int j = 0; j < 4; j++) begin
        oe = j[0];
        ue = j[1];
        mul(2'h3, rnd(220, 240), rnd(220, 240));
        mul(2'h0, rnd(20, 40), rnd(20, 40));
      end
      for (int j = 0; j < 2; j++) begin
        te = j[0];
        mul(2'h1, rnd(90, 150), 64'h8000_0000_0000_0000);
        neg(64'h8000_0000_0000_0000);
        neg(rnd(0, 0));
        neg(rnd(1, 1));
      end
    end
    // Reset in mid-run while in double mode must bring single mode back
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    dm = 1'b0;
    `CHK("mid reset mode", 1'b0, mode)
    `CHK("mid reset done", 1'b0, done)
    unknown_op();
    mul(2'h2, rnd(100, 150), rnd(100, 150));
    conclude();
  end
endmodule
`default_nettype wire
